// ### bench/headphone_output_power_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "hp_seq_map.vh"
module headphone_output_power_sequencer_bench;
    logic        mclk = 0, nrst = 0, regWrite = 0, regRead = 0, oscillatorEn = 0;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic [5:0]  leftPhonesVolume = 6'h00, rightPhonesVolume = 6'h00;
    logic [1:0]  servoComplete = 2'h0;
    wire  [15:0] regRdata;
    wire         seqBusy, servoStart, leftInputStageEn, rightInputStageEn, leftMidStageEn;
    wire         rightMidStageEn, leftOutStageEn, rightOutStageEn, leftPhonesGrounded;
    wire         rightPhonesGrounded, supplyPumpEn, pumpClkEn, pumpHighRail;
    wire  [2:0]  stages = {leftOutStageEn, leftMidStageEn, leftInputStageEn};
    int          miscompares = 0, comparisons = 0;
    headphone_output_power_sequencer dut (.*);
    initial forever #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 check("regRdata", regRdata, e);
    endtask
    // Bounded wait, a hang ends the run
    task automatic waitFor(input int k, input int lim);
        int i;
        for (i = 0; i < lim && stages[k] !== 1'b1; i++) @(posedge mclk) #1;
        if (i == lim) begin
            miscompares++;
            print_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic regsCheck;
        logic [7:0]  a [3] = '{`ADDR_POWER_MANAGEMENT_ONE, 8'h4C, `ADDR_ANALOGUE_HP_CONTROL};
        logic [15:0] m [3] = '{`MASK_PM1, `MASK_CP, `MASK_HP};
        for (int i = 0; i < 3; i++) begin
            rd(a[i], `RESET_REG);
            wr(a[i], 16'hFFFF);
            rd(a[i], m[i]);
            check("grounded", {leftPhonesGrounded, rightPhonesGrounded}, {2{i != 2}});
            check("enables", {leftInputStageEn, rightInputStageEn, supplyPumpEn, leftMidStageEn,
                rightMidStageEn, leftOutStageEn, rightOutStageEn},
                {m[i][9], m[i][8], m[i][15], m[i][5], m[i][1], m[i][6], m[i][2]});
            wr(a[i], 16'h0000);
        end
        rd(8'h22, 16'h0000);
    endtask
    task automatic pumpCheck;
        int n;
        wr(`ADDR_CHARGE_PUMP_CONTROL, `MASK_CP);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            oscillatorEn <= !k;
            leftPhonesVolume <= k ? 6'h2F : 6'h30;
            rightPhonesVolume <= k ? 6'h2F : 6'h00;
            n = 0;
            repeat (10) @(posedge mclk);
            repeat (100) @(posedge mclk) #1 n += pumpClkEn;
            check("pumpClkEn count", n[15:0], k ? 16'h0000 : 16'h0002);
            check("pumpHighRail", pumpHighRail, !k);
        end
        wr(`ADDR_CHARGE_PUMP_CONTROL, 16'h0000);
    endtask
    task automatic startupCheck;
        wr(`ADDR_SEQ_LAUNCH, `SEQ_STARTUP_CMD);
        @(posedge mclk) #1 check("supplyPumpEn", supplyPumpEn, 1'b1);
        // Dropped while the sequencer runs
        wr(`ADDR_ANALOGUE_HP_CONTROL, `MASK_HP);
        waitFor(0, 60000);
        check("mid early", leftMidStageEn, 1'b0);
        waitFor(1, 3000);
        check("mid stages", {rightInputStageEn, rightMidStageEn}, 2'h3);
        check("servoStart", servoStart, 1'b1);
        @(posedge mclk);
        servoComplete <= 2'h2;
        repeat (50) @(posedge mclk) #1;
        check("held", {leftOutStageEn, rightOutStageEn, leftPhonesGrounded}, 3'h1);
        @(posedge mclk);
        servoComplete <= 2'h3;
        waitFor(2, 10);
        check("released", {rightOutStageEn, leftPhonesGrounded, rightPhonesGrounded}, 3'h4);
        rd(`ADDR_ANALOGUE_HP_CONTROL, `MASK_HP);
    endtask
    // Only the first shut-down step fits the run length
    task automatic shutdownCheck;
        wr(`ADDR_SEQ_LAUNCH, `SEQ_SHUTDOWN_CMD);
        @(posedge mclk) #1 check("busy", seqBusy, 1'b1);
        check("outputs off", {leftMidStageEn, rightMidStageEn, leftOutStageEn, rightOutStageEn,
            leftPhonesGrounded, rightPhonesGrounded}, 6'h03);
        check("inputs kept", {leftInputStageEn, rightInputStageEn, supplyPumpEn}, 3'h7);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        regsCheck();
        pumpCheck();
        startupCheck();
        shutdownCheck();
        print_verdict();
    end
endmodule // headphone_output_power_sequencer_bench
bind headphone_output_power_sequencer hp_seq_sva chk (.*);
`default_nettype wire

// ### bench/hp_seq_sva.sv
`timescale 1ns/1ns
`default_nettype none
module hp_seq_sva (
    input wire logic        mclk, nrst, regWrite, regRead, seqBusy, servoStart,
    input wire logic        leftInputStageEn, rightInputStageEn, leftMidStageEn,
    input wire logic        rightMidStageEn, leftOutStageEn, supplyPumpEn,
    input wire logic        oscillatorEn, pumpClkEn, pumpHighRail,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWdata, regRdata,
    input wire logic [5:0]  leftPhonesVolume, rightPhonesVolume,
    input wire logic [1:0]  servoComplete
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Cycles since the left input stage came on, saturating
    logic [11:0] inputAge;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) inputAge <= 12'h000;
        else if (!leftInputStageEn) inputAge <= 12'h000;
        else if (inputAge != 12'hFFF) inputAge <= inputAge + 12'h001;
    end
    sequence launchStartup;
        regWrite && regAddr == 8'h49 && regWdata == 16'h0100 && !seqBusy;
    endsequence
    sequence midsUp;
        leftMidStageEn && rightMidStageEn && leftInputStageEn && rightInputStageEn;
    endsequence
    a_launch_pump_on: assert property (launchStartup |-> ##2 supplyPumpEn)
        else $error("pump not on after launch");
    a_servo_after_mid: assert property (servoStart |-> ##[0:2] midsUp)
        else $error("servo started before mid stages");
    a_servo_one_cycle: assert property (servoStart |=> !servoStart)
        else $error("servo start longer than one cycle");
    a_out_after_servo: assert property ($rose(leftOutStageEn) && seqBusy |->
        $past(servoComplete) == 2'h3) else $error("output stage before servo done");
    a_mid_input_delay: assert property ($rose(leftMidStageEn) && seqBusy |->
        inputAge >= 12'h7D0) else $error("mid stage too soon");
    a_pump_clk_gate: assert property (pumpClkEn |-> $past(oscillatorEn && supplyPumpEn))
        else $error("pump clock without oscillator and pump");
    a_pump_clk_gap: assert property (pumpClkEn |=> !pumpClkEn [*8])
        else $error("pump clock pulses too close");
    a_high_rail_mode: assert property (pumpHighRail == $past(supplyPumpEn &&
        (leftPhonesVolume >= 6'h30 || rightPhonesVolume >= 6'h30)))
        else $error("pump mode does not follow volume");
    a_unmapped_zero: assert property (regRead && !(regAddr inside {8'h01, 8'h49, 8'h4C,
        8'h60}) |=> regRdata == 16'h0000) else $error("unmapped read not zero");
endmodule // hp_seq_sva
`default_nettype wire

// ### rtl/headphone_output_power_sequencer.v
`timescale 1ns/1ns
`default_nettype none
`include "hp_seq_map.vh"

// Operation
// - Outputs stay grounded until short release set
// - Input-stage enables at bits 9 and 8
// - Left short, output, mid at 7,6,5
// - Right short, output, mid at 3,2,1
// - Bit 15 enables the supply pump
// - Pump mode follows headphone volume settings
// - Pump clock divided from system clock
// - Start-up enables pump, shut-down disables it
// - Writing 0100h to launch register starts start-up
module headphone_output_power_sequencer (
    input  wire        mclk,
    input  wire        nrst,
    input  wire        regWrite,
    input  wire        regRead,
    input  wire [7:0]  regAddr,
    input  wire [15:0] regWdata,
    output reg  [15:0] regRdata,
    output reg         seqBusy,
    input  wire        oscillatorEn,
    input  wire [5:0]  leftPhonesVolume,
    input  wire [5:0]  rightPhonesVolume,
    input  wire [1:0]  servoComplete,
    output reg         servoStart,
    output wire        leftInputStageEn,
    output wire        rightInputStageEn,
    output wire        leftMidStageEn,
    output wire        rightMidStageEn,
    output wire        leftOutStageEn,
    output wire        rightOutStageEn,
    output wire        leftPhonesGrounded,
    output wire        rightPhonesGrounded,
    output wire        supplyPumpEn,
    output reg         pumpClkEn,
    output reg         pumpHighRail
);

    localparam [3:0] ST_IDLE   = 4'h0;
    localparam [3:0] ST_PUMP   = 4'h1;
    localparam [3:0] ST_INPUT  = 4'h2;
    localparam [3:0] ST_MID    = 4'h3;
    localparam [3:0] ST_SERVO  = 4'h4;
    localparam [3:0] ST_OUT    = 4'h5;
    localparam [3:0] ST_SD_OUT = 4'h6;
    localparam [3:0] ST_SD_IN  = 4'h7;
    localparam [3:0] ST_SD_CP  = 4'h8;
    localparam [5:0] VOL_HIGH  = 6'h30;

    reg  [15:0]       pm1Q;
    reg  [15:0]       cpQ;
    reg  [15:0]       hpQ;
    reg  [3:0]        stateQ;
    reg  [`CNT_W-1:0] waitQ;
    reg  [15:0]       divQ;

    wire waitDone = (waitQ == {`CNT_W{1'b0}});

    function [15:0] mergeBits;
        input [15:0] oldVal;
        input [15:0] newVal;
        input [15:0] mask;
        begin
            mergeBits = (oldVal & ~mask) | (newVal & mask);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file and launch sequencer
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pm1Q       <= `RESET_REG;
            cpQ        <= `RESET_REG;
            hpQ        <= `RESET_REG;
            stateQ     <= ST_IDLE;
            waitQ      <= {`CNT_W{1'b0}};
            servoStart <= 1'b0;
        end else begin
            servoStart <= 1'b0;
            if (!waitDone)
                waitQ <= waitQ - 1'b1;
            if (regWrite && stateQ == ST_IDLE) begin
                case (regAddr)
                    `ADDR_POWER_MANAGEMENT_ONE: pm1Q <= mergeBits(pm1Q, regWdata, `MASK_PM1);
                    `ADDR_CHARGE_PUMP_CONTROL:  cpQ  <= mergeBits(cpQ, regWdata, `MASK_CP);
                    `ADDR_ANALOGUE_HP_CONTROL:  hpQ  <= mergeBits(hpQ, regWdata, `MASK_HP);
                    `ADDR_SEQ_LAUNCH: begin
                        if (regWdata == `SEQ_STARTUP_CMD) begin
                            stateQ <= ST_PUMP;
                        end else if (regWdata == `SEQ_SHUTDOWN_CMD) begin
                            stateQ <= ST_SD_OUT;
                        end
                    end
                    default: ;
                endcase
            end else if (waitDone) begin
                case (stateQ)
                    ST_IDLE: ;
                    ST_PUMP: begin
                        cpQ[`BIT_SUPPLY_PUMP_EN] <= 1'b1;
                        waitQ  <= `STEP_DELAY_CYC;
                        stateQ <= ST_INPUT;
                    end
                    ST_INPUT: begin
                        pm1Q[`BIT_LEFT_INPUT_STAGE_EN]  <= 1'b1;
                        pm1Q[`BIT_RIGHT_INPUT_STAGE_EN] <= 1'b1;
                        waitQ  <= `MID_STAGE_DELAY_CYC;
                        stateQ <= ST_MID;
                    end
                    ST_MID: begin
                        hpQ[`BIT_LEFT_MID_STAGE_EN]  <= 1'b1;
                        hpQ[`BIT_RIGHT_MID_STAGE_EN] <= 1'b1;
                        servoStart <= 1'b1;
                        stateQ     <= ST_SERVO;
                    end
                    ST_SERVO: begin
                        if (servoComplete == 2'h3)
                            stateQ <= ST_OUT;
                    end
                    ST_OUT: begin
                        hpQ[`BIT_LEFT_OUT_STAGE_EN]   <= 1'b1;
                        hpQ[`BIT_RIGHT_OUT_STAGE_EN]  <= 1'b1;
                        hpQ[`BIT_LEFT_SHORT_RELEASE]  <= 1'b1;
                        hpQ[`BIT_RIGHT_SHORT_RELEASE] <= 1'b1;
                        stateQ <= ST_IDLE;
                    end
                    ST_SD_OUT: begin
                        hpQ    <= `RESET_REG;
                        waitQ  <= `STEP_DELAY_CYC;
                        stateQ <= ST_SD_IN;
                    end
                    ST_SD_IN: begin
                        pm1Q[`BIT_LEFT_INPUT_STAGE_EN]  <= 1'b0;
                        pm1Q[`BIT_RIGHT_INPUT_STAGE_EN] <= 1'b0;
                        waitQ  <= `STEP_DELAY_CYC;
                        stateQ <= ST_SD_CP;
                    end
                    ST_SD_CP: begin
                        cpQ[`BIT_SUPPLY_PUMP_EN] <= 1'b0;
                        stateQ <= ST_IDLE;
                    end
                    default: stateQ <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback and status
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= `RESET_REG;
            seqBusy  <= 1'b0;
        end else begin
            seqBusy <= (stateQ != ST_IDLE);
            if (regRead) begin
                case (regAddr)
                    `ADDR_POWER_MANAGEMENT_ONE: regRdata <= pm1Q;
                    `ADDR_CHARGE_PUMP_CONTROL:  regRdata <= cpQ;
                    `ADDR_ANALOGUE_HP_CONTROL:  regRdata <= hpQ;
                    default:                    regRdata <= `RESET_REG;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage controls
    assign leftInputStageEn  = pm1Q[`BIT_LEFT_INPUT_STAGE_EN];
    assign rightInputStageEn = pm1Q[`BIT_RIGHT_INPUT_STAGE_EN];
    assign leftMidStageEn    = hpQ[`BIT_LEFT_MID_STAGE_EN];
    assign rightMidStageEn   = hpQ[`BIT_RIGHT_MID_STAGE_EN];
    assign leftOutStageEn    = hpQ[`BIT_LEFT_OUT_STAGE_EN];
    assign rightOutStageEn   = hpQ[`BIT_RIGHT_OUT_STAGE_EN];
    assign leftPhonesGrounded  = ~hpQ[`BIT_LEFT_SHORT_RELEASE];
    assign rightPhonesGrounded = ~hpQ[`BIT_RIGHT_SHORT_RELEASE];
    assign supplyPumpEn = cpQ[`BIT_SUPPLY_PUMP_EN];

    ////////////////////////////////////////////////////////////////////////
    // Pump clock divider and mode
    // Divider idles without the oscillator, so the pump gets no clock
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            divQ         <= 16'h0000;
            pumpClkEn    <= 1'b0;
            pumpHighRail <= 1'b0;
        end else begin
            if (oscillatorEn && supplyPumpEn) begin
                pumpClkEn <= (divQ == `PUMP_DIV);
                divQ      <= (divQ == `PUMP_DIV) ? 16'h0000 : divQ + 16'h0001;
            end else begin
                pumpClkEn <= 1'b0;
                divQ      <= 16'h0000;
            end
            pumpHighRail <= supplyPumpEn &&
                            (leftPhonesVolume >= VOL_HIGH || rightPhonesVolume >= VOL_HIGH);
        end
    end

endmodule // headphone_output_power_sequencer
`default_nettype wire

// ### rtl/hp_seq_map.vh
`ifndef HP_SEQ_MAP_VH
`define HP_SEQ_MAP_VH
// Register addresses
`define ADDR_POWER_MANAGEMENT_ONE   8'h01
`define ADDR_SEQ_LAUNCH             8'h49
`define ADDR_CHARGE_PUMP_CONTROL    8'h4C
`define ADDR_ANALOGUE_HP_CONTROL    8'h60
// Field positions
`define BIT_LEFT_INPUT_STAGE_EN     9
`define BIT_RIGHT_INPUT_STAGE_EN    8
`define BIT_LEFT_SHORT_RELEASE      7
`define BIT_LEFT_OUT_STAGE_EN       6
`define BIT_LEFT_MID_STAGE_EN       5
`define BIT_RIGHT_SHORT_RELEASE     3
`define BIT_RIGHT_OUT_STAGE_EN      2
`define BIT_RIGHT_MID_STAGE_EN      1
`define BIT_SUPPLY_PUMP_EN          15
// Register write masks and reset values
`define MASK_PM1                    16'h0300
`define MASK_CP                     16'h8000
`define MASK_HP                     16'h00EE
`define RESET_REG                   16'h0000
// Sequencer launch values
`define SEQ_STARTUP_CMD             16'h0100
`define SEQ_SHUTDOWN_CMD            16'h0110
// Timing, 100 MHz clock
// Wait counts of 20 us and 0.5 ms, sized to the wait counter
`define MID_STAGE_DELAY_CYC         20'h007D0
`define STEP_DELAY_CYC              20'h0C350
`define PUMP_DIV                    16'h0031
`define CNT_W                       20
`endif
